/* hw/sic_pkg.sv */
// Purpose: constants for the i2c pin-control block
// Assumes: 8-bit register port, 20 MHz system clock
// Notes: offsets are register indices on the plain port
package sic_pkg;
  localparam int unsigned ADDR_W = 10;
  // delay-setup register at its printed offset
  localparam logic [9:0] SDA_DELAY_SETUP_OFS = 10'h375;
  // control register holding the loose control bits
  localparam logic [9:0] PIN_CTRL_OFS = 10'h376;
  // status register showing pin state
  localparam logic [9:0] PIN_STAT_OFS = 10'h377;
  // pin-control field positions
  localparam int unsigned SCL_FORCE_LOW_BIT = 0;
  localparam int unsigned SDA_OUTPUT_DISABLE_BIT = 1;
  localparam int unsigned START_STOP_COND_CTRL_BIT = 2;
  localparam int unsigned DIGITAL_DELAY_SELECT_BIT = 3;
  localparam logic [7:0] PIN_CTRL_RST = 8'h00;
  // delay field bits 7..5, low bits unimplemented
  localparam int unsigned DLY_LSB = 5;
  localparam int unsigned DLY_W = 3;
  localparam logic [2:0] DLY_ANALOG = 3'h0;
  localparam logic [7:0] DLY_SETUP_RST = 8'h00;
  localparam logic [7:0] DLY_UNIMPL_MASK = 8'h1f;
  // main clock cycles per code step: code n gives 2n-1 to 2n cycles
  localparam int unsigned DLY_CYC_PER_CODE = 2;
  localparam int unsigned DLY_CNT_W = 4;
endpackage

/* hw/sic_sync.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: input is asynchronous to clk_i
// Notes: first stage read only by the second
`timescale 1ns/1ps
`default_nettype none
module sic_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // level
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 1'b1;
      q_o <= 1'b1;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule // sic_sync
`default_nettype wire

/* hw/sic_sda_delay.sv */
// Purpose: digital delay of the sda output level
// Assumes: code 0 means analog path, passed through one register
// Notes: counter restarts on every change of the source level
`timescale 1ns/1ps
`default_nettype none
module sic_sda_delay (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // setup
  input wire logic [2:0] code_i,
  // level
  input wire logic sda_i,
  output logic sda_o
);
  logic src_q;
  logic busy_q;
  logic [sic_pkg::DLY_CNT_W-1:0] cnt_q;
  logic [sic_pkg::DLY_CNT_W-1:0] load_w;
  logic change_w;
  // code n waits 2n-1 edges after the change edge, so 2n-1..2n cycles
  assign load_w = sic_pkg::DLY_CNT_W'({code_i, 1'b0}) - 4'h2;
  assign change_w = (sda_i != src_q);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      src_q <= 1'b1;
      busy_q <= 1'b0;
      cnt_q <= '0;
      sda_o <= 1'b1;
    end else begin
      src_q <= sda_i;
      if (code_i == sic_pkg::DLY_ANALOG) begin
        busy_q <= 1'b0;
        sda_o <= sda_i;
      end else if (change_w) begin
        busy_q <= 1'b1;
        cnt_q <= load_w;
      end else if (busy_q && cnt_q == '0) begin
        busy_q <= 1'b0;
        sda_o <= src_q;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule // sic_sda_delay
`default_nettype wire

/* hw/sic_pin_ctrl.sv */
// Purpose: i2c pin control: scl force low, sda disable and delay
// Assumes: transfer clock and sda data come from the channel core
// Notes: link clock is sampled through two flops like any pin
`timescale 1ns/1ps
`default_nettype none
// Contract
// - scl follows transfer clock, or forced low
// - sda disable bit puts sda high impedance
// - unimplemented delay bits written zero, read undefined
// - digital delay select makes those bits read zero
// - digital delay select gives defined reset value
// - delay code 000 selects analog path
// - code 001 delays 1-2 cycles, longer codes more
module sic_pin_ctrl (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  // register port
  input wire logic [9:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // channel core side
  input wire logic XFER_CLK_I,
  input wire logic SDA_DATA_I,
  output logic START_STOP_COND_CTRL_O,
  // i2c pins, enables active low
  input wire logic SCL_PIN_I,
  output logic SCL_O,
  output logic SCL_OE_N_O,
  input wire logic SDA_PIN_I,
  output logic SDA_O,
  output logic SDA_OE_N_O
);
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] dly_q;
  logic [7:0] dly_d;
  logic [7:0] rdata_d;
  logic xclk_s;
  logic scl_s;
  logic sda_s;
  logic sda_dly;
  logic scl_q;
  logic sda_q;
  logic sda_dis_q;
  logic sel_ctrl_w;
  logic sel_dly_w;
  logic sel_stat_w;
  logic dig_sel_w;
  logic [2:0] code_w;
  logic [7:0] dly_rd_w;
  logic scl_low_w;
  logic sda_dis_w;

  function automatic logic hit(input logic [9:0] a, input logic [9:0] o);
    hit = (a == o);
  endfunction

  sic_sync u_sync_xclk (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .d_i(XFER_CLK_I),
    .q_o(xclk_s)
  );
  sic_sync u_sync_scl (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .d_i(SCL_PIN_I),
    .q_o(scl_s)
  );
  sic_sync u_sync_sda (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .d_i(SDA_PIN_I),
    .q_o(sda_s)
  );

  assign sel_ctrl_w = hit(ADDR_I, sic_pkg::PIN_CTRL_OFS);
  assign sel_dly_w = hit(ADDR_I, sic_pkg::SDA_DELAY_SETUP_OFS);
  assign sel_stat_w = hit(ADDR_I, sic_pkg::PIN_STAT_OFS);
  assign dig_sel_w = ctrl_q[sic_pkg::DIGITAL_DELAY_SELECT_BIT];
  assign scl_low_w = ctrl_q[sic_pkg::SCL_FORCE_LOW_BIT];
  assign sda_dis_w = ctrl_q[sic_pkg::SDA_OUTPUT_DISABLE_BIT];
  assign code_w = dly_q[sic_pkg::DLY_LSB +: sic_pkg::DLY_W];
  // low bits are not stored; read zero under digital select
  // and otherwise the stored zero, a legal undefined value
  assign dly_rd_w = dig_sel_w ? (dly_q & ~sic_pkg::DLY_UNIMPL_MASK)
                              : dly_q;
  // only four control bits exist
  assign ctrl_d = (WR_I && sel_ctrl_w) ? {4'h0, WDATA_I[3:0]} : ctrl_q;
  // software writes low bits as zero; hardware keeps them zero anyway
  assign dly_d = (WR_I && sel_dly_w)
               ? (WDATA_I & ~sic_pkg::DLY_UNIMPL_MASK) : dly_q;
  assign rdata_d = !RD_I ? 8'h00
                 : sel_ctrl_w ? ctrl_q
                 : sel_dly_w ? dly_rd_w
                 : sel_stat_w ? {5'h00, sda_dis_q, sda_s, scl_s}
                 : 8'h00;

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ctrl_q <= sic_pkg::PIN_CTRL_RST;
      // defined reset for every case, which covers digital select
      dly_q <= sic_pkg::DLY_SETUP_RST;
      RDATA_O <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      dly_q <= dly_d;
      RDATA_O <= rdata_d;
    end
  end

  sic_sda_delay u_dly (
    .clk_i(CLK_SYS_I),
    .rst_i(SYS_RST_I),
    .code_i(code_w),
    .sda_i(SDA_DATA_I),
    .sda_o(sda_dly)
  );

  // open-drain style: drive only low levels
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_dis_q <= 1'b0;
    end else begin
      scl_q <= scl_low_w ? 1'b0 : xclk_s;
      sda_q <= sda_dly;
      sda_dis_q <= sda_dis_w;
    end
  end

  assign START_STOP_COND_CTRL_O = ctrl_q[sic_pkg::START_STOP_COND_CTRL_BIT];
  assign SCL_O = 1'b0;
  assign SCL_OE_N_O = scl_q;
  assign SDA_O = 1'b0;
  assign SDA_OE_N_O = sda_dis_q | sda_q;
endmodule // sic_pin_ctrl
`default_nettype wire

/* test/sic_pin_ctrl_properties.sv */
// Purpose: port checker for the i2c pin-control block
// Assumes: ctrl and delay bits mirrored from bus writes
// Notes: settled sda assumed before each edge checked
`timescale 1ns/1ps
`default_nettype none
module sic_pin_ctrl_chk (
  // watched ports
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  input wire logic [9:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic XFER_CLK_I,
  input wire logic SDA_DATA_I,
  input wire logic START_STOP_COND_CTRL_O,
  input wire logic SCL_OE_N_O,
  input wire logic SDA_OE_N_O
);
  logic [1:0] c_q;
  logic [2:0] d_q;
  wire wc = WR_I && ADDR_I == sic_pkg::PIN_CTRL_OFS;
  wire wd = WR_I && ADDR_I == sic_pkg::SDA_DELAY_SETUP_OFS;
  wire rdl = RD_I && ADDR_I == sic_pkg::SDA_DELAY_SETUP_OFS;
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      c_q <= 2'h0;
      d_q <= 3'h0;
    end else begin
      if (wc) c_q <= WDATA_I[1:0];
      if (wd) d_q <= WDATA_I[7:5];
    end
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  a_delay_readback: assert property (rdl |=>
    RDATA_O == {$past(d_q), 5'h00}) else $error("delay readback wrong");
  a_scl_forced: assert property (wc && WDATA_I[0] |->
    ##2 !SCL_OE_N_O [*3]) else $error("scl not forced low");
  a_scl_follow: assert property ((!c_q[0] && $stable(XFER_CLK_I)) [*5]
    |-> SCL_OE_N_O == XFER_CLK_I) else $error("scl not following");
  a_sda_released: assert property (wc && WDATA_I[1] |->
    ##3 SDA_OE_N_O) else $error("sda not released");
  a_start_stop: assert property (wc |-> ##2
    START_STOP_COND_CTRL_O == $past(WDATA_I[2], 2)) else $error("ssc");
  a_analog_path: assert property ((d_q == 3'h0 && !c_q[1] &&
    $stable(SDA_DATA_I)) [*4] |-> SDA_OE_N_O == SDA_DATA_I)
    else $error("analog path wrong");
  a_delay_one: assert property (d_q == 3'h1 && !c_q[1] &&
    $changed(SDA_DATA_I) |=> SDA_OE_N_O != SDA_DATA_I ##[1:4]
    SDA_OE_N_O == SDA_DATA_I) else $error("code one delay wrong");
  a_delay_two: assert property (d_q == 3'h2 && !c_q[1] &&
    $changed(SDA_DATA_I) |=> (SDA_OE_N_O != SDA_DATA_I) [*3] ##[1:4]
    SDA_OE_N_O == SDA_DATA_I) else $error("code two delay wrong");
  cover property (wc && WDATA_I[0]);
  cover property (d_q == 3'h2 && $changed(SDA_DATA_I));
  cover property (rdl);
endmodule // sic_pin_ctrl_chk
bind sic_pin_ctrl sic_pin_ctrl_chk sic_pin_ctrl_chk_inst (.*);
`default_nettype wire

/* test/sic_bus_model.sv */
// Purpose: i2c bus wires with pull-ups
// Assumes: every party is open drain
// Notes: no peer pulls low in these tests
`timescale 1ns/1ps
`default_nettype none
module sic_bus_model (
  // enables, low drives the wire low
  input wire logic scl_oe_n_i,
  input wire logic sda_oe_n_i,
  // wire levels
  output logic scl_o,
  output logic sda_o
);
  assign scl_o = scl_oe_n_i;
  assign sda_o = sda_oe_n_i;
endmodule // sic_bus_model
`default_nettype wire

/* test/sic_pin_ctrl_bench.sv */
// Purpose: bench for the i2c pin-control block
// Assumes: register map of sic_pkg
// Notes: link clock runs only inside frames
`timescale 1ns/1ps
`default_nettype none
module sic_pin_ctrl_bench;
  logic CLK_SYS_I, SYS_RST_I, WR_I, RD_I, XFER_CLK_I, SDA_DATA_I, run;
  logic SCL_PIN_I, SDA_PIN_I, SCL_O, SDA_O, SCL_OE_N_O, SDA_OE_N_O;
  logic START_STOP_COND_CTRL_O;
  logic [9:0] ADDR_I;
  logic [7:0] WDATA_I, RDATA_O;
  int fail_count, checked, n, k;
  sic_pin_ctrl sic_pin_ctrl_inst (.*);
  sic_bus_model sic_bus_model_inst (.scl_oe_n_i(SCL_OE_N_O),
    .sda_oe_n_i(SDA_OE_N_O), .scl_o(SCL_PIN_I), .sda_o(SDA_PIN_I));
  initial begin
    CLK_SYS_I = 0;
    forever #25 CLK_SYS_I = ~CLK_SYS_I;
  end
  initial begin
    XFER_CLK_I = 1'b0;
    #13;
    forever #200 if (run) XFER_CLK_I = ~XFER_CLK_I;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge CLK_SYS_I) {WR_I, ADDR_I, WDATA_I} <= {1'b1, a, d};
    @(posedge CLK_SYS_I) WR_I <= 0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge CLK_SYS_I) {RD_I, ADDR_I} <= {1'b1, a};
    @(posedge CLK_SYS_I) RD_I <= 0;
    #1 chk(RDATA_O, e);
  endtask
  task automatic rst;
    @(posedge CLK_SYS_I) SYS_RST_I <= 1;
    repeat (5) @(posedge CLK_SYS_I);
    SYS_RST_I <= 0;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    give_verdict;
  end
  initial begin
    {SYS_RST_I, WR_I, RD_I, run} = 4'h8;
    {ADDR_I, WDATA_I, SDA_DATA_I} = 19'h00001;
    rst;
    rd(sic_pkg::SDA_DELAY_SETUP_OFS, 8'h00);
    rd(10'h000, 8'h00);
    wr(sic_pkg::PIN_CTRL_OFS, 8'h0c);
    rd(sic_pkg::PIN_CTRL_OFS, 8'h0c);
    chk({7'h00, START_STOP_COND_CTRL_O}, 8'h01);
    for (n = 0; n < 3; n++) begin
      wr(sic_pkg::SDA_DELAY_SETUP_OFS, 8'(n << 5));
      rd(sic_pkg::SDA_DELAY_SETUP_OFS, 8'(n << 5));
      k = 0;
      @(posedge CLK_SYS_I) SDA_DATA_I <= 0;
      while (SDA_OE_N_O !== 1'b0 && k < 20) @(posedge CLK_SYS_I) #1 k++;
      chk(8'(k >= (n > 0 ? 2*n+1 : 1) && k <= 2*n+3), 8'h01);
      @(posedge CLK_SYS_I) SDA_DATA_I <= 1;
      repeat (10) @(posedge CLK_SYS_I);
    end
    $display("test sda delay done");
    wr(sic_pkg::PIN_CTRL_OFS, 8'h0e);
    @(posedge CLK_SYS_I) SDA_DATA_I <= 0;
    repeat (8) @(posedge CLK_SYS_I);
    #1 chk({7'h00, SDA_OE_N_O}, 8'h01);
    // status: disable set, released sda high, scl low with idle clock
    rd(sic_pkg::PIN_STAT_OFS, 8'h06);
    chk({6'h00, SCL_O, SDA_O}, 8'h00);
    run = 1;
    repeat (40) @(posedge CLK_SYS_I);
    wr(sic_pkg::PIN_CTRL_OFS, 8'h0d);
    repeat (20) @(posedge CLK_SYS_I);
    #1 chk({7'h00, SCL_OE_N_O}, 8'h00);
    run = 0;
    wr(sic_pkg::PIN_CTRL_OFS, 8'h0c);
    repeat (10) @(posedge CLK_SYS_I);
    #1 chk(SCL_OE_N_O, {7'h00, XFER_CLK_I});
    $display("test pins done");
    rst;
    rd(sic_pkg::SDA_DELAY_SETUP_OFS, 8'h00);
    chk({7'h00, START_STOP_COND_CTRL_O}, 8'h00);
    $display("test reset done");
    give_verdict;
  end
endmodule // sic_pin_ctrl_bench
`default_nettype wire
